// File: hdl/protection_status_registers.sv
/*
  Protection status register group: live fault view, latched event register
  cleared on read or by command, latch mask, shutdown request and the
  protection summary that feeds the status byte.
  Assumes the command decoder presents one request per cycle, synchronous to clock_i.
*/
`timescale 1ns/1ps

module protection_status_registers
  import prot_status_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic [31:0] fault_state_i,
  input  wire host_req_s   host_req_i,
  input  wire logic [7:0]  service_request_mask_i,
  output host_rsp_s        host_rsp_o,
  output logic             shutdown_o,
  output logic             prot_summary_o,
  output logic [7:0]       status_byte_o
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic [31:0] live_fault_condition;
  logic [31:0] latched_fault_event_reg;
  logic [31:0] latched_fault_event_next;
  logic [31:0] fault_latch_mask_reg;
  logic [31:0] fault_latch_mask_next;
  host_rsp_s   rsp_reg;
  host_rsp_s   rsp_next;
  logic [31:0] rise_set;
  logic [31:0] prev_state_reg;
  logic        is_live_q;
  logic        is_event_q;
  logic        is_mask_q;
  logic        is_mask_w;
  logic        is_clear;
  logic [31:0] shut_bits;

  assign is_live_q  = host_req_i.valid && (host_req_i.cmd == CMD_LIVE_QUERY);
  assign is_event_q = host_req_i.valid && (host_req_i.cmd == CMD_EVENT_QUERY);
  assign is_mask_q  = host_req_i.valid && (host_req_i.cmd == CMD_MASK_QUERY);
  assign is_mask_w  = host_req_i.valid && (host_req_i.cmd == CMD_MASK_WRITE);
  assign is_clear   = host_req_i.valid &&
                      ((host_req_i.cmd == CMD_CLEAR_STATUS) || (host_req_i.cmd == CMD_RESET));

  // Live view, no latching; unused bit 17 and 21-31 forced low
  assign live_fault_condition = fault_state_i & USED_MASK & ~BIT_NOT_USED;

  // Event is a condition turning on; a standing fault latches once, not every cycle
  assign rise_set = live_fault_condition & ~prev_state_reg & fault_latch_mask_reg;

  // Set wins over clear so an event in the clearing cycle is not lost
  assign latched_fault_event_next = ((is_event_q || is_clear) ? ZERO_WORD : latched_fault_event_reg)
                                    | rise_set;

  assign fault_latch_mask_next = is_mask_w ? (host_req_i.wdata & USED_MASK) : fault_latch_mask_reg;

  assign rsp_next.valid = is_live_q || is_event_q || is_mask_q;
  assign rsp_next.rdata = is_live_q  ? live_fault_condition :
                          is_event_q ? latched_fault_event_reg :
                          is_mask_q  ? fault_latch_mask_reg : ZERO_WORD;

  // Mode bits only count when enabled
  assign shut_bits = live_fault_condition & (~MODE_BITS | (MODE_BITS & fault_latch_mask_reg));

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (!resetn_i)
    begin
      latched_fault_event_reg <= ZERO_WORD;
      fault_latch_mask_reg    <= MASK_RESET;
      prev_state_reg          <= ZERO_WORD;
      rsp_reg                 <= '0;
    end
    else
    begin
      latched_fault_event_reg <= latched_fault_event_next;
      fault_latch_mask_reg    <= fault_latch_mask_next;
      prev_state_reg          <= live_fault_condition;
      rsp_reg                 <= rsp_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign host_rsp_o     = rsp_reg;
  assign shutdown_o     = |shut_bits;
  assign prot_summary_o = |latched_fault_event_reg;
  // Request bit follows the summary only when service requests are enabled
  assign status_byte_o  = (prot_summary_o ? STB_PROT : 8'h00) |
                          (((service_request_mask_i & STB_PROT) != 8'h00) && prot_summary_o ? STB_RQS : 8'h00);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_event_read;
    host_req_i.valid && host_req_i.cmd == CMD_EVENT_QUERY;
  endsequence

  sequence s_any_query;
    is_live_q || is_event_q || is_mask_q;
  endsequence

  // Host spaces its requests, so a readback follows the write after one idle cycle
  sequence s_mask_write_query;
    is_mask_w ##1 !is_mask_w ##1 is_mask_q;
  endsequence

  sequence s_masked_rise;
    rise_set != ZERO_WORD;
  endsequence

  chk_live_answer_now: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_live_q |=> host_rsp_o.valid && host_rsp_o.rdata == ($past(fault_state_i) & USED_MASK & ~BIT_NOT_USED))
    else $error("live answer wrong");
  chk_upper_bits_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (latched_fault_event_reg & ~USED_MASK) == ZERO_WORD)
    else $error("unused latched bits set");
  chk_read_clears: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_event_read |=> (latched_fault_event_reg & ~$past(rise_set)) == ZERO_WORD)
    else $error("event read did not clear");
  chk_cmd_clears: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_clear && rise_set == ZERO_WORD |=> latched_fault_event_reg == ZERO_WORD)
    else $error("clear command ignored");
  chk_masked_stays: assert property (@(posedge clock_i) disable iff (!resetn_i)
    ##1 ((latched_fault_event_reg & ~$past(latched_fault_event_reg) & ~$past(fault_latch_mask_reg)) == ZERO_WORD))
    else $error("masked bit latched");
  chk_latch_holds: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !is_event_q && !is_clear |=> (latched_fault_event_reg & $past(latched_fault_event_reg))
                                  == $past(latched_fault_event_reg))
    else $error("latched bit lost");
  chk_mask_readback: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_mask_write_query |=> host_rsp_o.rdata == ($past(host_req_i.wdata, 3) & USED_MASK))
    else $error("mask readback wrong");
  chk_mode_no_shut: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (live_fault_condition & ~MODE_BITS) == ZERO_WORD && (fault_latch_mask_reg & MODE_BITS) == ZERO_WORD
    |-> !shutdown_o)
    else $error("mode change shut down");
  chk_fault_shuts: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (live_fault_condition & ~MODE_BITS) != ZERO_WORD |-> shutdown_o)
    else $error("fault without shutdown");
  chk_status_byte: assert property (@(posedge clock_i) disable iff (!resetn_i)
    service_request_mask_i == STB_PROT && latched_fault_event_reg != ZERO_WORD |-> status_byte_o == 8'h42)
    else $error("status byte not 0x42");

  // ---------------------------------------------------------------
  // Answer timing and register contents
  // ---------------------------------------------------------------
  // One answer per query, one cycle later; writes and clears stay silent
  chk_query_answered: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_any_query |=> host_rsp_o.valid)
    else $error("query not answered");
  chk_no_stray_answer: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !(is_live_q || is_event_q || is_mask_q) |=> !host_rsp_o.valid)
    else $error("answer without query");
  chk_answer_upper_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    host_rsp_o.valid |-> (host_rsp_o.rdata & ~USED_MASK) == ZERO_WORD)
    else $error("answer has unused bits set");
  chk_event_answer: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_event_read |=> host_rsp_o.rdata == $past(latched_fault_event_reg))
    else $error("event answer wrong");
  chk_mask_answer: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_mask_q |=> host_rsp_o.rdata == $past(fault_latch_mask_reg))
    else $error("mask answer wrong");
  chk_mask_write_lands: assert property (@(posedge clock_i) disable iff (!resetn_i)
    is_mask_w |=> fault_latch_mask_reg == ($past(host_req_i.wdata) & USED_MASK))
    else $error("mask write lost");
  chk_mask_holds: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !is_mask_w |=> $stable(fault_latch_mask_reg))
    else $error("mask changed without write");
  chk_mask_upper_zero: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (fault_latch_mask_reg & ~USED_MASK) == ZERO_WORD)
    else $error("unused mask bits set");

  // ---------------------------------------------------------------
  // Latching, summary and shutdown
  // ---------------------------------------------------------------
  // Set wins: an event in a read or clear cycle must survive
  chk_event_latches: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_masked_rise |=> (latched_fault_event_reg & $past(rise_set)) == $past(rise_set))
    else $error("masked event not latched");
  chk_summary_set: assert property (@(posedge clock_i) disable iff (!resetn_i)
    s_masked_rise |=> prot_summary_o)
    else $error("summary missing after event");
  chk_summary_drops: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (is_event_q || is_clear) && rise_set == ZERO_WORD |=> !prot_summary_o)
    else $error("summary stuck after clear");
  chk_status_prot_bit: assert property (@(posedge clock_i) disable iff (!resetn_i)
    prot_summary_o |-> (status_byte_o & STB_PROT) == STB_PROT)
    else $error("summary bit missing in status byte");
  chk_status_idle: assert property (@(posedge clock_i) disable iff (!resetn_i)
    !prot_summary_o |-> status_byte_o == 8'h00)
    else $error("status byte set without summary");
  chk_rqs_needs_mask: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (service_request_mask_i & STB_PROT) == 8'h00 |-> (status_byte_o & STB_RQS) == 8'h00)
    else $error("request bit without mask");
  chk_mode_masked_shuts: assert property (@(posedge clock_i) disable iff (!resetn_i)
    (live_fault_condition & MODE_BITS & fault_latch_mask_reg) != ZERO_WORD |-> shutdown_o)
    else $error("enabled mode did not shut down");

endmodule

// File: common/prot_status_pkg.sv
/*
  Package for the protection status register group: fault bit layout,
  register selectors, command codes and the packed carriers used at the ports.
  Assumes a command decoder elsewhere turns host text into selector strobes.
*/
package prot_status_pkg;

  // ---------------------------------------------------------------
  // Register geometry
  // ---------------------------------------------------------------
  localparam int          REG_W         = 32;
  localparam int          FAULT_BITS    = 21;
  localparam logic [31:0] USED_MASK     = 32'h001F_FFFF;
  localparam logic [31:0] MASK_RESET    = 32'h0000_0000;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Bit values in the live and latched registers
  // ---------------------------------------------------------------
  localparam logic [31:0] BIT_CV        = 32'h0000_0001;
  localparam logic [31:0] BIT_CC        = 32'h0000_0002;
  localparam logic [31:0] BIT_CP        = 32'h0000_0004;
  localparam logic [31:0] BIT_OVP       = 32'h0000_0008;
  localparam logic [31:0] BIT_FOLDBACK  = 32'h0000_0040;
  localparam logic [31:0] BIT_NOT_USED  = 32'h0002_0000;
  localparam logic [31:0] BIT_LAST      = 32'h0010_0000;
  localparam logic [31:0] MODE_BITS     = BIT_CV | BIT_CC | BIT_CP | BIT_FOLDBACK;

  // ---------------------------------------------------------------
  // Status byte positions
  // ---------------------------------------------------------------
  localparam logic [7:0]  STB_PROT      = 8'h02;
  localparam logic [7:0]  STB_RQS       = 8'h40;

  // ---------------------------------------------------------------
  // Host command codes
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_NONE,
    CMD_LIVE_QUERY,
    CMD_EVENT_QUERY,
    CMD_MASK_QUERY,
    CMD_MASK_WRITE,
    CMD_CLEAR_STATUS,
    CMD_RESET
  } host_cmd_e;

  typedef struct packed {
    logic        valid;
    host_cmd_e   cmd;
    logic [31:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
  } host_rsp_s;

endpackage

// File: dv/host_model.sv
/*
  Host model: sends one-cycle command requests to the status registers.
  Assumes the bench calls send from one sequence, one call at a time.
*/
`timescale 1ns/1ps
module host_model
  import prot_status_pkg::*;
(
  input  wire logic clock_i,
  output host_req_s host_req_o
);
  // ------------------------------
  // Request driver
  // ------------------------------
  initial host_req_o = '0;
  // One idle cycle between calls; simpler than chaining, costs little here
  task automatic send(input host_cmd_e cmd, input logic [31:0] wdata);
    @(posedge clock_i);
    host_req_o <= '{valid: 1'b1, cmd: cmd, wdata: wdata};
    @(posedge clock_i);
    // Released fields toggle so a stale word never looks valid
    host_req_o <= '{valid: 1'b0, cmd: CMD_NONE, wdata: ~wdata};
  endtask
endmodule

// File: dv/protection_status_registers_bench.sv
/*
  Bench for the protection status registers, driven through the host model.
  Assumes the package and design are compiled first.
*/
`timescale 1ns/1ps
module protection_status_registers_bench
  import prot_status_pkg::*;
;
  logic        clock_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic [31:0] flt_in = 32'h0000_0000;
  logic [7:0]  sr_mask = 8'h00;
  host_req_s   req;
  host_rsp_s   rsp;
  logic        shutdown;
  logic        summary;
  logic [7:0]  stb;
  logic [31:0] exp_q[$];
  logic [31:0] mask;
  logic [31:0] flt;
  host_cmd_e   clr[2] = '{CMD_CLEAR_STATUS, CMD_RESET};
  int          fails = 0;
  int          n_checks = 0;
  int          cycles = 0;
  integer      seed = 23;

  always #12.5 clock_i = ~clock_i;

  host_model host (.clock_i(clock_i), .host_req_o(req));
  protection_status_registers dut (.clock_i(clock_i), .resetn_i(resetn_i), .fault_state_i(flt_in),
    .host_req_i(req), .service_request_mask_i(sr_mask), .host_rsp_o(rsp), .shutdown_o(shutdown),
    .prot_summary_o(summary), .status_byte_o(stb));

  // ------------------------------
  // Checking and closing
  // ------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, seen);
      fails++;
    end
  endtask

  task automatic end_of_test();
    check("pending answers", 32'(exp_q.size()), ZERO_WORD);
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic query(input host_cmd_e cmd, input logic [31:0] exp);
    exp_q.push_back(exp);
    host.send(cmd, ZERO_WORD);
    repeat (2) @(posedge clock_i);
  endtask

  task automatic set_fault(input logic [31:0] f);
    @(posedge clock_i);
    flt_in <= f;
    repeat (2) @(posedge clock_i);
  endtask

  function automatic logic [31:0] live(input logic [31:0] f);
    return f & USED_MASK & ~BIT_NOT_USED;
  endfunction

  always @(posedge clock_i)
  begin
    if (resetn_i === 1'b1 && rsp.valid === 1'b1)
    begin
      if (exp_q.size() == 0)
        check("extra answer", 32'h0000_0001, 32'h0000_0000);
      else
        check("answer", rsp.rdata, exp_q.pop_front());
    end
  end

  // Ceiling well above the roughly 150 cycles the sequence needs
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ------------------------------
  // Main sequence
  // ------------------------------
  initial
  begin
    repeat (4) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    check("summary", 32'(summary), ZERO_WORD);
    check("status byte", 32'(stb), ZERO_WORD);
    query(CMD_MASK_QUERY, MASK_RESET);
    repeat (6)
    begin
      mask = $random(seed);
      flt = $random(seed);
      host.send(CMD_MASK_WRITE, mask);
      query(CMD_MASK_QUERY, mask & USED_MASK);
      set_fault(flt);
      query(CMD_LIVE_QUERY, live(flt));
      @(negedge clock_i);
      check("shutdown", 32'(shutdown), 32'(|(live(flt) & (~MODE_BITS | mask))));
    end
    set_fault(ZERO_WORD);
    host.send(CMD_CLEAR_STATUS, ZERO_WORD);
    sr_mask <= STB_PROT;
    host.send(CMD_MASK_WRITE, BIT_OVP | BIT_CV);
    set_fault(BIT_FOLDBACK | BIT_CC);
    @(negedge clock_i);
    check("shutdown", 32'(shutdown), ZERO_WORD);
    set_fault(BIT_FOLDBACK | BIT_CV);
    @(negedge clock_i);
    check("shutdown", 32'(shutdown), 32'h0000_0001);
    set_fault(BIT_OVP | BIT_CV | BIT_FOLDBACK);
    set_fault(ZERO_WORD);
    @(negedge clock_i);
    check("summary", 32'(summary), 32'h0000_0001);
    check("status byte", 32'(stb), 32'h0000_0042);
    query(CMD_EVENT_QUERY, BIT_OVP | BIT_CV);
    query(CMD_EVENT_QUERY, ZERO_WORD);
    @(negedge clock_i);
    check("summary", 32'(summary), ZERO_WORD);
    foreach (clr[i])
    begin
      set_fault(BIT_OVP);
      sr_mask <= (i == 0) ? STB_PROT : 8'h00;
      set_fault(ZERO_WORD);
      @(negedge clock_i);
      check("status byte", 32'(stb), 32'(STB_PROT | ((i == 0) ? STB_RQS : 8'h00)));
      host.send(clr[i], ZERO_WORD);
      query(CMD_EVENT_QUERY, ZERO_WORD);
    end
    query(CMD_MASK_QUERY, BIT_OVP | BIT_CV);
    repeat (3) @(posedge clock_i);
    end_of_test();
  end
endmodule
